// ### rtl/iefl_pkg.sv
package iefl_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] INT_CTRL_IDX_LO   = 8'h0b;
  localparam logic [7:0] INT_CTRL_IDX_HI   = 8'h8b;
  localparam logic [7:0] PERIPH_EN_IDX     = 8'h8c;
  localparam logic [7:0] PERIPH_FLAG_IDX   = 8'h0c;
  localparam logic [7:0] OPTION_IDX        = 8'h81;
  localparam logic [7:0] PORT_B_DATA_IDX   = 8'h40;

  // ****************************************************************
  // interrupt_control field positions
  // ****************************************************************
  localparam int unsigned GLOBAL_EN_BIT    = 7;
  localparam int unsigned PERIPH_EN_BIT    = 6;
  localparam int unsigned T0_EN_BIT        = 5;
  localparam int unsigned EXT_EN_BIT       = 4;
  localparam int unsigned PB_EN_BIT        = 3;
  localparam int unsigned T0_FLAG_BIT      = 2;
  localparam int unsigned EXT_FLAG_BIT     = 1;
  localparam int unsigned PB_FLAG_BIT      = 0;

  // ****************************************************************
  // peripheral enable / flag field positions
  // ****************************************************************
  localparam int unsigned ADC_BIT          = 6;
  localparam int unsigned SERIAL_BIT       = 3;
  localparam int unsigned CAPCMP_BIT       = 2;
  localparam int unsigned T2_BIT           = 1;
  localparam int unsigned T1_BIT           = 0;
  localparam logic [7:0]  PERIPH_MASK      = 8'h4f;

  // ****************************************************************
  // option register field
  // ****************************************************************
  localparam int unsigned EDGE_POL_BIT     = 6;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [4:0]  CTRL_EN_RESET    = 5'h00;
  localparam logic [2:0]  CORE_FLAG_RESET  = 3'h0;
  localparam logic [4:0]  PERIPH_RESET     = 5'h00;
  localparam logic        EDGE_POL_RESET   = 1'b1;
  localparam logic [3:0]  PB_LATCH_RESET   = 4'h0;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

  // ****************************************************************
  // bus slave phase
  // ****************************************************************
  typedef enum logic [0:0] {
    APB_IDLE,
    APB_ANSWER
  } iefl_apb_state_t;

endpackage

// ### rtl/iefl_flag_bank.sv
module iefl_flag_bank #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // software side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // hardware events
  input  wire logic [WIDTH-1:0] set_vec,
  // sticky flags
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // software write first, then events on top so a set is never lost
  always_comb begin
    flags_next = flags_reg;
    if (wr_en) begin
      flags_next = wr_data;
    end
    flags_next = flags_next | set_vec;
  end

  // flags only fall when software writes zero
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= RESET_VALUE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// ### rtl/iefl_top.sv
// Notes on behaviour
// - interrupt_control answers at two indices sharing one storage
// - global_int_enable clear blocks every request to the core
// - periph_int_enable set passes unmasked peripheral-group sources
// - timer-zero flag interrupts only while timer0_ovf_enable set
// - external pin flag interrupts only while ext_pin_int_enable set
// - peripheral_interrupt_enable answers at one index
// - enable bits 7, 5, 4 read zero and ignore writes
// - converter flag gated by adc_done_enable
// - serial port flag gated by serial_port_enable
// - timer-one overflow flag gated by timer1_ovf_enable
// - no peripheral source interrupts without periph_int_enable
// - flags set regardless of any enable; enables mask requests only
// - external flag on rising edge if polarity one, else falling
// - timer-one overflow sets a flag that only software clears
// - timer-two period match sets a flag cleared by software
// - serial transfer completion sets a flag held until cleared
module iefl_top
  import iefl_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // peripheral event pulses
  input  wire logic              TIMER0_OVF,
  input  wire logic              TIMER1_OVF,
  input  wire logic              TIMER2_MATCH,
  input  wire logic              SERIAL_DONE,
  input  wire logic              CAPCMP_EVENT,
  input  wire logic              ADC_DONE,
  // pins
  input  wire logic              EXTERNAL_INTERRUPT_PIN,
  input  wire logic [3:0]        PORT_B_HIGH_PINS,
  // request to the core
  output logic                   IRQ
);

  // ****************************************************************
  // address decode helpers
  // ****************************************************************

  // word index of a bus address; byte lanes below are ignored
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[ADDR_W-1:2];
  endfunction

  // true when the address hits a given register index
  function automatic logic hits(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        idx);
    hits = (word_index(a) == {2'b00, idx});
  endfunction

  // scatter five peripheral bits into their byte positions
  function automatic logic [7:0] periph_to_byte(input logic [4:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[ADC_BIT]    = v[4];
    b[SERIAL_BIT] = v[3];
    b[CAPCMP_BIT] = v[2];
    b[T2_BIT]     = v[1];
    b[T1_BIT]     = v[0];
    periph_to_byte = b;
  endfunction

  // gather the five implemented peripheral bits from a byte
  function automatic logic [4:0] byte_to_periph(input logic [7:0] b);
    byte_to_periph = {b[ADC_BIT], b[SERIAL_BIT], b[CAPCMP_BIT],
                      b[T2_BIT], b[T1_BIT]};
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  iefl_apb_state_t   apb_state_reg;
  iefl_apb_state_t   apb_state_next;
  logic [DATA_W-1:0] prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              irq_reg;

  logic [4:0]        ctrl_en_reg;      // global, periph, t0, ext, pb
  logic [4:0]        periph_en_reg;    // adc, serial, capcmp, t2, t1
  logic              edge_pol_reg;
  logic              ext_pin_prev_reg;
  logic [3:0]        pb_latch_reg;

  logic              setup_phase;
  logic              commit;
  logic              wr_commit;
  logic              rd_commit;
  logic              lane0;
  logic              sel_ctrl;
  logic              sel_pen;
  logic              sel_pflag;
  logic              sel_opt;
  logic              sel_pb;
  logic              mapped;
  logic [7:0]        wbyte;
  logic [7:0]        rbyte;

  logic [2:0]        core_flags;
  logic [2:0]        core_set;
  logic [4:0]        periph_flags;
  logic [4:0]        periph_set;
  logic              ext_edge;
  logic              pb_mismatch;
  logic              core_req;
  logic              periph_req;

  // ****************************************************************
  // apb handshake
  // ****************************************************************

  // the answer is prepared in setup so every output leaves a flop
  assign setup_phase = PSEL && !PENABLE && (apb_state_reg == APB_IDLE);
  assign commit      = PSEL && PENABLE && pready_reg;
  assign wr_commit   = commit && PWRITE;
  assign rd_commit   = commit && !PWRITE;
  assign lane0       = PSTRB[0];
  assign wbyte       = PWDATA[REG_W-1:0];

  // one answer state; pready drops right after the committing edge
  always_comb begin
    apb_state_next = apb_state_reg;
    case (apb_state_reg)
      APB_IDLE: begin
        if (setup_phase) begin
          apb_state_next = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        if (commit || !PSEL) begin
          apb_state_next = APB_IDLE;
        end
      end
      default: begin
        apb_state_next = APB_IDLE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      apb_state_reg <= APB_IDLE;
    end else begin
      apb_state_reg <= apb_state_next;
    end
  end

  // ready raised for exactly the first access cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign sel_ctrl  = hits(PADDR, INT_CTRL_IDX_LO) ||
                     hits(PADDR, INT_CTRL_IDX_HI);
  assign sel_pen   = hits(PADDR, PERIPH_EN_IDX);
  assign sel_pflag = hits(PADDR, PERIPH_FLAG_IDX);
  assign sel_opt   = hits(PADDR, OPTION_IDX);
  assign sel_pb    = hits(PADDR, PORT_B_DATA_IDX);
  assign mapped    = sel_ctrl || sel_pen || sel_pflag || sel_opt || sel_pb;

  // read byte for the address now on the bus
  always_comb begin
    rbyte = 8'h00;
    if (sel_ctrl) begin
      rbyte = {ctrl_en_reg, core_flags};
    end else if (sel_pen) begin
      rbyte = periph_to_byte(periph_en_reg);
    end else if (sel_pflag) begin
      rbyte = periph_to_byte(periph_flags);
    end else if (sel_opt) begin
      rbyte = 8'h00;
      rbyte[EDGE_POL_BIT] = edge_pol_reg;
    end else if (sel_pb) begin
      rbyte = {PORT_B_HIGH_PINS, 3'b000, EXTERNAL_INTERRUPT_PIN};
    end
  end

  // read data and error captured in setup, held through access
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prdata_reg  <= RDATA_RESET;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= PWRITE ? RDATA_RESET : {24'h00_0000, rbyte};
      pslverr_reg <= !mapped;
    end else if (commit) begin
      pslverr_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // enable registers
  // ****************************************************************

  // enable half of interrupt_control, same storage for both indices
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_en_reg <= CTRL_EN_RESET;
    end else if (wr_commit && sel_ctrl && lane0) begin
      ctrl_en_reg <= wbyte[REG_W-1:3];
    end
  end

  // unimplemented positions are simply never stored
  always_ff @(posedge CLK) begin
    if (RESET) begin
      periph_en_reg <= PERIPH_RESET;
    end else if (wr_commit && sel_pen && lane0) begin
      periph_en_reg <= byte_to_periph(wbyte);
    end
  end

  // edge polarity choice for the external pin
  always_ff @(posedge CLK) begin
    if (RESET) begin
      edge_pol_reg <= EDGE_POL_RESET;
    end else if (wr_commit && sel_opt && lane0) begin
      edge_pol_reg <= wbyte[EDGE_POL_BIT];
    end
  end

  // ****************************************************************
  // event detection
  // ****************************************************************

  // previous pin level for edge detection
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_pin_prev_reg <= 1'b0;
    end else begin
      ext_pin_prev_reg <= EXTERNAL_INTERRUPT_PIN;
    end
  end

  // rising when polarity is one, falling when zero
  assign ext_edge = edge_pol_reg ?
                    (EXTERNAL_INTERRUPT_PIN && !ext_pin_prev_reg) :
                    (!EXTERNAL_INTERRUPT_PIN && ext_pin_prev_reg);

  // the latch follows the pins only when software reads the port,
  // so a mismatch keeps re-setting the flag until that read
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pb_latch_reg <= PB_LATCH_RESET;
    end else if (rd_commit && sel_pb) begin
      pb_latch_reg <= PORT_B_HIGH_PINS;
    end
  end

  assign pb_mismatch = (PORT_B_HIGH_PINS != pb_latch_reg);

  // ****************************************************************
  // sticky flags
  // ****************************************************************

  // flags rise whatever the enables say
  assign core_set = {TIMER0_OVF, ext_edge, pb_mismatch};

  iefl_flag_bank #(
    .WIDTH       (3),
    .RESET_VALUE (CORE_FLAG_RESET)
  ) u_core_flags (
    .clk     (CLK),
    .reset   (RESET),
    .wr_en   (wr_commit && sel_ctrl && lane0),
    .wr_data (wbyte[2:0]),
    .set_vec (core_set),
    .flags   (core_flags)
  );

  // peripheral flags, cleared only by a software write of zero
  assign periph_set = {ADC_DONE, SERIAL_DONE, CAPCMP_EVENT,
                       TIMER2_MATCH, TIMER1_OVF};

  iefl_flag_bank #(
    .WIDTH       (5),
    .RESET_VALUE (PERIPH_RESET)
  ) u_periph_flags (
    .clk     (CLK),
    .reset   (RESET),
    .wr_en   (wr_commit && sel_pflag && lane0),
    .wr_data (byte_to_periph(wbyte)),
    .set_vec (periph_set),
    .flags   (periph_flags)
  );

  // ****************************************************************
  // request to the core
  // ****************************************************************

  // core-group pairs, each flag masked by its own enable
  assign core_req =
    (ctrl_en_reg[T0_EN_BIT-3] && core_flags[T0_FLAG_BIT])   ||
    (ctrl_en_reg[EXT_EN_BIT-3] && core_flags[EXT_FLAG_BIT]) ||
    (ctrl_en_reg[PB_EN_BIT-3] && core_flags[PB_FLAG_BIT]);

  // peripheral pairs, then the group gate above them all
  assign periph_req = ctrl_en_reg[PERIPH_EN_BIT-3] &&
    ((periph_en_reg[4] && periph_flags[4]) ||
     (periph_en_reg[3] && periph_flags[3]) ||
     (periph_en_reg[2] && periph_flags[2]) ||
     (periph_en_reg[1] && periph_flags[1]) ||
     (periph_en_reg[0] && periph_flags[0]));

  // registered request; one cycle behind flags, trading latency for a
  // glitch-free output. pending flags left set before enabling fire at
  // once, which is why software clears them first
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ctrl_en_reg[GLOBAL_EN_BIT-3] &&
                 (core_req || periph_req);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ     = irq_reg;

endmodule

// ### dv/iefl_src_model.sv
module iefl_src_model (
  // clock and control
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [31:0] rnd,
  // event pulses
  output logic             t0,
  output logic             t1,
  output logic             t2,
  output logic             ser,
  output logic             cap,
  output logic             adc,
  // pins
  output logic             pin,
  output logic [3:0]       pb
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet sources until the bench starts traffic
  initial begin
    {t0, t1, t2, ser, cap, adc, pin, pb} = '0;
  end

  // one-cycle event pulses; pins move only while running
  always @(posedge clk) begin
    t0  <= run & rnd[0] & rnd[1];
    t1  <= run & rnd[2] & rnd[3];
    t2  <= run & rnd[4] & rnd[5];
    ser <= run & rnd[6] & rnd[7];
    cap <= run & rnd[8] & rnd[9];
    adc <= run & rnd[10] & rnd[11];
    if (run) begin
      pin <= rnd[12] ^ rnd[13];
      // rare changes, so a later clear can still stick
      if (rnd[20] & rnd[21] & rnd[22]) begin
        pb <= rnd[19:16];
      end
    end
  end
endmodule

// ### dv/iefl_asserts.sv
module iefl_chk
  import iefl_pkg::*;
(
  // clock and reset
  input wire logic              CLK,
  input wire logic              RESET,
  // apb
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic [3:0]        PSTRB,
  input wire logic [DATA_W-1:0] PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // events and pins
  input wire logic              TIMER0_OVF,
  input wire logic              TIMER1_OVF,
  input wire logic              TIMER2_MATCH,
  input wire logic              SERIAL_DONE,
  input wire logic              CAPCMP_EVENT,
  input wire logic              ADC_DONE,
  input wire logic              EXTERNAL_INTERRUPT_PIN,
  input wire logic [3:0]        PORT_B_HIGH_PINS,
  // request
  input wire logic              IRQ
);
  logic [7:0] idx;
  logic       hi0;
  logic       wc;
  logic       is_ctl;
  logic       mapped;
  logic [7:3] ctl;
  logic [7:0] pie;
  logic [7:0] pev;

  // decode helpers
  assign idx    = PADDR[9:2];
  assign hi0    = PADDR[11:10] == 2'b00;
  assign wc     = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  assign is_ctl = hi0 && (idx == INT_CTRL_IDX_LO || idx == INT_CTRL_IDX_HI);
  assign mapped = is_ctl || hi0 && (idx == PERIPH_EN_IDX ||
                  idx == PERIPH_FLAG_IDX || idx == OPTION_IDX ||
                  idx == PORT_B_DATA_IDX);
  assign pev    = pie & {1'b0, ADC_DONE, 2'b00, SERIAL_DONE, CAPCMP_EVENT,
                         TIMER2_MATCH, TIMER1_OVF};

  // shadow of enables; only software moves them, so ports suffice
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl <= 5'h00;
      pie <= 8'h00;
    end else if (wc && is_ctl) begin
      ctl <= PWDATA[7:3];
    end else if (wc && hi0 && idx == PERIPH_EN_IDX) begin
      pie <= PWDATA[7:0] & PERIPH_MASK;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_READY_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in first access cycle");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  AST_ERR_MAP: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error flag does not match decode");
  AST_PIE_READ: assert property (PREADY && !PWRITE && hi0 &&
    idx == PERIPH_EN_IDX |-> PRDATA == {24'h00_0000, pie})
    else $error("enable register read wrong");
  AST_CTL_READ: assert property (PREADY && !PWRITE && is_ctl
    |-> PRDATA[7:3] == ctl)
    else $error("control enables read wrong");
  AST_GLOBAL_OFF: assert property (!ctl[7] |=> !IRQ)
    else $error("request while global enable clear");
  AST_PERIPH_OFF: assert property (ctl[7] && !ctl[6] &&
    ctl[5:3] == 3'b000 |=> !IRQ)
    else $error("peripheral request while group blocked");
  AST_STICKY: assert property ($fell(IRQ) && !$past(RESET)
    |-> $past(wc, 2))
    else $error("request dropped without a write");
  AST_T0_PATH: assert property (ctl[7] && ctl[5] && TIMER0_OVF && !wc
    |-> ##2 IRQ)
    else $error("timer zero overflow gave no request");
  AST_PER_PATH: assert property (ctl[7] && ctl[6] && (|pev) && !wc
    |-> ##2 IRQ)
    else $error("peripheral event gave no request");

  COV_HI_WRITE: cover property (wc && hi0 && idx == INT_CTRL_IDX_HI);
  COV_IRQ: cover property ($rose(IRQ));
  COV_ERR: cover property (PSLVERR);
endmodule

bind iefl_top iefl_chk i_iefl_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER0_OVF(TIMER0_OVF), .TIMER1_OVF(TIMER1_OVF),
  .TIMER2_MATCH(TIMER2_MATCH), .SERIAL_DONE(SERIAL_DONE),
  .CAPCMP_EVENT(CAPCMP_EVENT), .ADC_DONE(ADC_DONE),
  .EXTERNAL_INTERRUPT_PIN(EXTERNAL_INTERRUPT_PIN),
  .PORT_B_HIGH_PINS(PORT_B_HIGH_PINS), .IRQ(IRQ));

// ### dv/iefl_tb_top.sv
module iefl_tb_top
  import iefl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic        t0, t1, t2, ser, cap, adc, pin, go;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rnd, m_rd;
  logic [3:0]  PSTRB, pb, m_lat;
  logic [7:0]  m_ctl, m_pie, m_pfl, m_opt, m_pset;
  logic [2:0]  m_cset;
  logic        m_prv, m_irq, m_err;
  int          failures, num_checks;
  logic [7:0]  idx_tab [7] = '{INT_CTRL_IDX_LO, INT_CTRL_IDX_HI,
    PERIPH_EN_IDX, PERIPH_FLAG_IDX, OPTION_IDX, PORT_B_DATA_IDX, 8'h33};
  // last entry: global on, group and core enables off, all peripherals on
  logic [7:0]  ctl_tab [7] = '{8'h78, 8'hb8, 8'hc0, 8'he0, 8'hd0, 8'hc8,
                               8'h80};
  logic [7:0]  pie_tab [7] = '{8'hff, 8'hff, 8'h40, 8'h08, 8'h04, 8'h03,
                               8'hff};

  iefl_top i_iefl_top (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TIMER0_OVF(t0), .TIMER1_OVF(t1), .TIMER2_MATCH(t2), .SERIAL_DONE(ser),
    .CAPCMP_EVENT(cap), .ADC_DONE(adc), .EXTERNAL_INTERRUPT_PIN(pin),
    .PORT_B_HIGH_PINS(pb), .IRQ(IRQ));
  iefl_src_model i_iefl_src_model (.clk(CLK), .run(go), .rnd(rnd), .t0(t0),
    .t1(t1), .t2(t2), .ser(ser), .cap(cap), .adc(adc), .pin(pin), .pb(pb));

  // 20 MHz clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // fixed-seed random source feeding the event model
  always @(posedge CLK) rnd <= xs(rnd);

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // reference model; sets are merged after writes so set beats clear
  always @(posedge CLK) begin
    if (RESET) begin
      {m_ctl, m_pie, m_pfl, m_lat, m_prv, m_irq, m_err, m_rd} = '0;
      m_opt = 8'h40;
    end else begin
      check({31'h0, IRQ}, {31'h0, m_irq}, "irq");
      m_cset = {t0, 2'b00};
      m_cset[1] = pin != m_prv && pin == m_opt[6];
      m_cset[0] = pb != m_lat;
      m_pset = {1'b0, adc, 2'b00, ser, cap, t2, t1};
      m_irq = m_ctl[7] & ((|(m_ctl[5:3] & m_ctl[2:0])) |
              (m_ctl[6] & (|(m_pie & m_pfl))));
      if (PSEL && !PENABLE) begin
        m_err = PADDR[11:10] != 2'b00;
        case (PADDR[9:2])
          INT_CTRL_IDX_LO, INT_CTRL_IDX_HI: m_rd = {24'h0, m_ctl};
          PERIPH_EN_IDX: m_rd = {24'h0, m_pie};
          PERIPH_FLAG_IDX: m_rd = {24'h0, m_pfl};
          OPTION_IDX: m_rd = {24'h0, m_opt};
          PORT_B_DATA_IDX: m_rd = {24'h0, pb, 3'b000, pin};
          default: m_err = 1'b1;
        endcase
        if (m_err) m_rd = '0;
      end
      if (PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !m_err) begin
        case (PADDR[9:2])
          INT_CTRL_IDX_LO, INT_CTRL_IDX_HI: m_ctl = PWDATA[7:0];
          PERIPH_EN_IDX: m_pie = PWDATA[7:0] & PERIPH_MASK;
          PERIPH_FLAG_IDX: m_pfl = PWDATA[7:0] & PERIPH_MASK;
          OPTION_IDX: m_opt = PWDATA[7:0] & 8'h40;
          default: ;
        endcase
      end
      if (PSEL && PENABLE && PREADY && !PWRITE && !m_err &&
          PADDR[9:2] == PORT_B_DATA_IDX) m_lat = pb;
      m_ctl[2:0] = m_ctl[2:0] | m_cset;
      m_pfl = m_pfl | m_pset;
      m_prv = pin;
    end
  end

  // one apb transfer; holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {2'b00, a, 2'b00};
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // no latency assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    if (!w) check(PRDATA, m_rd, "read data");
    check({31'h0, PSLVERR}, {31'h0, m_err}, "slave error");
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of about 770 cycles
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end

  initial begin
    {RESET, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB, go} = '0;
    RESET = 1'b1;
    rnd = 32'h1577;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    foreach (idx_tab[i]) apb(1'b0, idx_tab[i], '0, 4'hf);
    apb(1'b1, INT_CTRL_IDX_HI, 32'h0000_00ff, 4'h0);
    apb(1'b1, PERIPH_EN_IDX, 32'h0000_00ff, 4'hf);
    apb(1'b1, 8'h33, 32'h0000_00ff, 4'hf);
    apb(1'b1, PERIPH_FLAG_IDX, 32'h0000_00ff, 4'hf);
    foreach (idx_tab[i]) apb(1'b0, idx_tab[i], '0, 4'hf);
    for (int i = 0; i < 7; i++) begin
      // flags cleared before enabling, as software must
      apb(1'b1, INT_CTRL_IDX_LO, '0, 4'hf);
      apb(1'b1, PERIPH_FLAG_IDX, '0, 4'hf);
      apb(1'b1, OPTION_IDX, {25'h0, i[0], 6'h00}, 4'hf);
      apb(1'b1, PERIPH_EN_IDX, {24'h0, pie_tab[i]}, 4'hf);
      apb(1'b1, INT_CTRL_IDX_HI, {24'h0, ctl_tab[i]}, 4'hf);
      go <= 1'b1;
      repeat (60) @(posedge CLK);
      go <= 1'b0;
      repeat (3) @(posedge CLK);
      foreach (idx_tab[j]) apb(1'b0, idx_tab[j], '0, 4'hf);
    end
    test_done;
  end
endmodule
